// ===== hdl/mode_register_access_unit.v
`timescale 1ns/1ps
`include "mode_reg_regs.vh"
module mode_register_access_unit #(
	parameter DQ_WIDTH = 16,
	parameter READ_LATENCY = `READ_LATENCY,
	parameter WRITE_PERIOD = `REG_WRITE_CMD_PERIOD,
	parameter [31:0] TEMP_UPDATE_CYCLES = `TEMP_UPDATE_CYCLES,
	parameter [31:0] INIT_CYCLES = `SOFT_RESET_INIT_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire link_ck,
	input wire cs_n,
	input wire [9:0] ca,
	input wire [2:0] temp_sensor,
	input wire banks_active,
	output reg [DQ_WIDTH-1:0] dq_out,
	output reg dq_oe,
	output reg [DQ_WIDTH/8-1:0] dqs_out,
	output reg dqs_oe,
	output wire busy,
	output wire init_busy
);
	localparam LANES = DQ_WIDTH / 8;
	localparam ST_IDLE = 4'b0001;
	localparam ST_LAT = 4'b0010;
	localparam ST_BURST = 4'b0100;
	localparam ST_INIT = 4'b1000;

	// ************************************
	// Input synchronisation
	// ************************************
	wire [14:0] sync_q;
	link_sync #(.WIDTH(15)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({temp_sensor, banks_active, link_ck, cs_n, ca[8:0]}),
		.q(sync_q)
	);
	// ca[9] not synchronised alongside; add separately
	reg ca9_meta_reg;
	reg ca9_reg;
	always @(posedge clk) begin
		if (rst) begin
			ca9_meta_reg <= 1'b0;
			ca9_reg <= 1'b0;
		end else begin
			ca9_meta_reg <= ca[9];
			ca9_reg <= ca9_meta_reg;
		end
	end
	wire [9:0] ca_s = {ca9_reg, sync_q[8:0]};
	wire cs_n_s = sync_q[9];
	wire ck_s = sync_q[10];
	wire act_s = sync_q[11];
	wire [2:0] temp_s = sync_q[14:12];

	reg ck_d_reg;
	always @(posedge clk) begin
		if (rst)
			ck_d_reg <= 1'b0;
		else
			ck_d_reg <= ck_s;
	end
	wire ck_rise = ck_s & ~ck_d_reg;
	wire ck_fall = ~ck_s & ck_d_reg;

	// ************************************
	// Command capture
	// ************************************
	reg [3:0] state_reg;
	reg pend_rd_reg;
	reg pend_wr_reg;
	reg [5:0] addr_hi_reg;
	reg [3:0] hold_reg;
	reg [3:0] lat_reg;
	reg [2:0] beat_reg;
	reg [31:0] init_cnt_reg;
	reg [7:0] rdata_reg;
	reg cal_reg;
	reg [3:0] cal_pat_reg;
	reg [7:0] regfile [0:31];
	reg [2:0] temp_status_reg;
	reg [31:0] tsi_cnt_reg;
	integer i;
	// Command period as a plain count, sliced to the counter
	localparam READ_HOLD = `REG_READ_CMD_PERIOD;

	// ************************************
	// Address decoding
	// ************************************
	// Temperature slot stays read-only
	function is_writable;
		input [7:0] a;
		begin
			is_writable = (a >= `WR_FIRST) && (a <= `WR_LAST) &&
				(a != `ADDR_TEMP_STATUS);
		end
	endfunction

	// Calibration slots answer with a fixed pattern
	function is_cal;
		input [7:0] a;
		begin
			is_cal = (a == `ADDR_CAL_A) || (a == `ADDR_CAL_B);
		end
	endfunction

	// Status in low bits; unmapped slots read zero
	function [7:0] read_value;
		input [7:0] a;
		input [2:0] temp;
		input [7:0] stored;
		begin
			if (a == `ADDR_TEMP_STATUS)
				read_value = {5'b0_0000, temp};
			else if (is_writable(a))
				read_value = stored;
			else
				read_value = 8'h00;
		end
	endfunction

	wire [7:0] addr_full = {addr_hi_reg, ca_s[1:0]};
	wire rd_cmd = ck_rise & ~cs_n_s & (ca_s[3:0] == `CMD_MR_READ);
	wire wr_cmd = ck_rise & ~cs_n_s & (ca_s[3:0] == `CMD_MR_WRITE);

	assign busy = (state_reg != ST_IDLE) | (hold_reg != 4'h0);
	assign init_busy = (state_reg == ST_INIT);

	// ************************************
	// Beat words per byte lane
	// ************************************
	// Pattern bit for the beat about to be driven
	wire cal_bit = (state_reg == ST_LAT) ? cal_pat_reg[0] :
		cal_pat_reg[beat_reg[1:0] + 2'd1];
	wire [DQ_WIDTH-1:0] first_word;
	wire [DQ_WIDTH-1:0] cal_word;
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			// Upper lanes get a defined zero filler
			if (g == 0) begin : g_low
				assign first_word[7:0] = rdata_reg;
			end else begin : g_up
				assign first_word[g*8 +: 8] = 8'h00;
			end
			assign cal_word[g*8 +: 8] = {8{cal_bit}};
		end
	endgenerate

	// ************************************
	// Register access sequencer
	// ************************************
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_INIT;
			pend_rd_reg <= 1'b0;
			pend_wr_reg <= 1'b0;
			addr_hi_reg <= 6'h00;
			hold_reg <= 4'h0;
			lat_reg <= 4'h0;
			beat_reg <= 3'd0;
			init_cnt_reg <= 32'h0000_0000;
			rdata_reg <= 8'h00;
			cal_reg <= 1'b0;
			cal_pat_reg <= 4'h0;
			dq_out <= {DQ_WIDTH{1'b0}};
			dq_oe <= 1'b0;
			dqs_out <= {LANES{1'b0}};
			dqs_oe <= 1'b0;
			for (i = 0; i < 32; i = i + 1)
				regfile[i] <= 8'h00;
		end else begin
			if (ck_rise && hold_reg != 4'h0)
				hold_reg <= hold_reg - 4'h1;
			case (state_reg)
			ST_INIT: begin
				dq_oe <= 1'b0;
				dqs_oe <= 1'b0;
				pend_rd_reg <= 1'b0;
				pend_wr_reg <= 1'b0;
				if (init_cnt_reg >= INIT_CYCLES) begin
					init_cnt_reg <= 32'h0000_0000;
					state_reg <= ST_IDLE;
				end else
					init_cnt_reg <= init_cnt_reg + 32'h0000_0001;
			end
			ST_IDLE: begin
				if (hold_reg == 4'h0 && (rd_cmd || wr_cmd)) begin
					addr_hi_reg <= ca_s[9:4];
					pend_rd_reg <= rd_cmd;
					pend_wr_reg <= wr_cmd;
				end
				if (ck_fall && (pend_rd_reg || pend_wr_reg)) begin
					pend_rd_reg <= 1'b0;
					pend_wr_reg <= 1'b0;
					if (pend_rd_reg) begin
						hold_reg <= READ_HOLD[3:0];
						lat_reg <= READ_LATENCY[3:0];
						state_reg <= ST_LAT;
						cal_reg <= is_cal(addr_full);
						cal_pat_reg <= (addr_full == `ADDR_CAL_A) ?
							`CAL_A_PATTERN : `CAL_B_PATTERN;
						rdata_reg <= read_value(addr_full,
							temp_status_reg, regfile[addr_full[4:0]]);
					end else begin
						hold_reg <= WRITE_PERIOD[3:0];
						if (addr_full == `ADDR_SOFT_RESET) begin
							for (i = 0; i < 32; i = i + 1)
								regfile[i] <= 8'h00;
							state_reg <= ST_INIT;
						end else if (is_writable(addr_full))
							regfile[addr_full[4:0]] <= ca_s[9:2];
					end
				end
			end
			ST_LAT: begin
				// Wait read latency in link cycles
				if (ck_rise) begin
					if (lat_reg <= 4'h1) begin
						state_reg <= ST_BURST;
						beat_reg <= 3'd0;
						dq_oe <= 1'b1;
						dqs_oe <= 1'b1;
						dqs_out <= {LANES{1'b1}};
						// Register value on the low lane
						dq_out <= cal_reg ? cal_word : first_word;
					end else
						lat_reg <= lat_reg - 4'h1;
				end
			end
			ST_BURST: begin
				// Four beats, one per link edge
				if (ck_rise || ck_fall) begin
					if (beat_reg == 3'd3) begin
						state_reg <= ST_IDLE;
						dq_oe <= 1'b0;
						dqs_oe <= 1'b0;
						dqs_out <= {LANES{1'b0}};
					end else begin
						beat_reg <= beat_reg + 3'd1;
						dqs_out <= ~dqs_out;
						dq_out <= cal_reg ? cal_word : {DQ_WIDTH{1'b0}};
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ************************************
	// Temperature status refresh
	// ************************************
	// Periodic update, bounded by interval
	always @(posedge clk) begin
		if (rst) begin
			tsi_cnt_reg <= 32'h0000_0000;
			temp_status_reg <= 3'b000;
		end else if (tsi_cnt_reg >= TEMP_UPDATE_CYCLES - 32'h0000_0001) begin
			tsi_cnt_reg <= 32'h0000_0000;
			temp_status_reg <= temp_s;
		end else
			tsi_cnt_reg <= tsi_cnt_reg + 32'h0000_0001;
	end
	// Bank-active input only observed, kept for future checks
	wire unused_act = act_s;
endmodule

// ===== hdl/mode_reg_regs.vh
`ifndef MODE_REG_REGS_VH
`define MODE_REG_REGS_VH
// Command decode on rising-edge CA[3:0]
`define CMD_MR_READ 4'h8
`define CMD_MR_WRITE 4'h0
// Register addresses
`define ADDR_TEMP_STATUS 8'h04
`define ADDR_CAL_A 8'h20
`define ADDR_CAL_B 8'h28
`define ADDR_SOFT_RESET 8'h3F
// Writable register file range
`define WR_FIRST 8'h01
`define WR_LAST 8'h1F
// Calibration patterns, beat 0 in bit 0
`define CAL_A_PATTERN 4'h5
`define CAL_B_PATTERN 4'hC
// Timing
`define CLK_PERIOD_NS 5
`define TEMP_UPDATE_INTERVAL_MS 32
`define TEMP_UPDATE_CYCLES 32'd6_400_000
`define SOFT_RESET_INIT_TIME_US 1
`define SOFT_RESET_INIT_CYCLES ((`SOFT_RESET_INIT_TIME_US*1000)/`CLK_PERIOD_NS)
`define REG_READ_CMD_PERIOD 2
`define REG_WRITE_CMD_PERIOD 5
`define READ_LATENCY 3
`define MR_BURST_BEATS 4
`endif

// ===== hdl/link_sync.v
`timescale 1ns/1ps
module link_sync #(
	parameter WIDTH = 1
) (
	clk,
	rst,
	d,
	q
);
	input wire clk;
	input wire rst;
	input wire [WIDTH-1:0] d;
	output reg [WIDTH-1:0] q;
	reg [WIDTH-1:0] meta_reg;

	// Two flops; only q is used downstream
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ===== test/mrau_monitor.sv
`timescale 1ns/1ps
// ****
// Read burst checks
// ****
module mrau_monitor #(
	parameter DQ_WIDTH = 16
) (
	input wire clk,
	input wire rst,
	input wire link_ck,
	input wire cs_n,
	input wire [9:0] ca,
	input wire [2:0] temp_sensor,
	input wire banks_active,
	input wire [DQ_WIDTH-1:0] dq_out,
	input wire dq_oe,
	input wire [DQ_WIDTH/8-1:0] dqs_out,
	input wire dqs_oe,
	input wire busy,
	input wire init_busy
);
	reg [DQ_WIDTH/8-1:0] last_reg;
	reg [7:0] chg_reg;
	reg [7:0] stay_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Strobe edges and quiet spans per burst
	always @(posedge clk) begin
		last_reg <= dqs_out;
		if (rst || !dqs_oe) begin
			chg_reg <= 8'h00;
			stay_reg <= 8'h00;
		end else if (dqs_out != last_reg) begin
			chg_reg <= chg_reg + 8'h01;
			stay_reg <= 8'h00;
		end else begin
			stay_reg <= stay_reg + 8'h01;
		end
	end
	sequence s_start; $rose(dqs_oe); endsequence
	property p_oe_pair; dq_oe == dqs_oe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("oe split");
	property p_dqs_first; s_start |-> &dqs_out; endproperty
	a_dqs_first: assert property (p_dqs_first) else $error("dqs");
	// Half link period is 8 clocks, three spare for sync jitter
	property p_toggle; stay_reg <= 8'h0a; endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle");
	property p_four; $fell(dqs_oe) |-> chg_reg == 8'h04; endproperty
	a_four: assert property (p_four) else $error("beats");
	property p_align;
		dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(dqs_out);
	endproperty
	a_align: assert property (p_align) else $error("beat skew");
	property p_init; init_busy |-> !dq_oe; endproperty
	a_init: assert property (p_init) else $error("init out");
	property p_busy; dq_oe |-> busy; endproperty
	a_busy: assert property (p_busy) else $error("not busy");
	property p_rst; $fell(rst) |-> !dq_oe && !dqs_oe; endproperty
	a_rst: assert property (p_rst) else $error("reset out");
endmodule
bind mode_register_access_unit mrau_monitor #(.DQ_WIDTH(DQ_WIDTH))
	u_mrau_monitor (.clk(clk), .rst(rst), .link_ck(link_ck),
	.cs_n(cs_n), .ca(ca), .temp_sensor(temp_sensor),
	.banks_active(banks_active), .dq_out(dq_out), .dq_oe(dq_oe),
	.dqs_out(dqs_out), .dqs_oe(dqs_oe), .busy(busy),
	.init_busy(init_busy));

// ===== test/ctrl_model.sv
`timescale 1ns/1ps
// ****
// Controller side of the command bus
// ****
module ctrl_model #(
	parameter DW = 16
) (
	input wire clk,
	output reg link_ck,
	output reg cs_n,
	output reg [9:0] ca,
	input wire [DW-1:0] dq_out,
	input wire dq_oe
);
	reg [4*DW-1:0] beats;
	integer nb;
	initial begin
		link_ck = 1'b0;
		cs_n = 1'b1;
		ca = 10'h000;
	end
	// Lines move mid-phase, clear of the sampled edges
	task ed(input v, input [10:0] nx);
	begin
		link_ck = v;
		#20 {cs_n, ca} = nx;
		#10 if (dq_oe) begin
			// Count every driven beat so a long burst shows
			if (nb < 4)
				beats[nb*DW +: DW] = dq_out;
			nb = nb + 1;
		end
		#10;
	end
	endtask
	// opcode, then low address and data
	task cmd(input rd, input [7:0] a, input [7:0] d);
	integer i;
	begin
		nb = 0;
		beats = {4*DW{1'bx}};
		// Launch just after a clock edge, never on it
		@(posedge clk) #1 {cs_n, ca} = {1'b0, a[7:2], rd, 3'b000};
		#20 ed(1'b1, {1'b0, d, a[1:0]});
		for (i = 1; i < 26; i = i + 1) ed(~i[0], {1'b1, ~ca});
	end
	endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
// ****
// Register access bench
// ****
module tb_top;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg banks_active = 1'b0;
	reg [2:0] temp_sensor = 3'h3;
	wire link_ck, cs_n, dq_oe, dqs_oe, busy, init_busy;
	wire [9:0] ca;
	wire [15:0] dq_out;
	wire [1:0] dqs_out;
	reg [63:0] b;
	integer miscompares = 0;
	integer num_checks = 0;
	integer i;
	always #2.5 clk = ~clk;
	mode_register_access_unit #(.TEMP_UPDATE_CYCLES(32'h0000_0064))
		u_mode_register_access_unit (.clk(clk), .rst(rst),
		.link_ck(link_ck), .cs_n(cs_n), .ca(ca),
		.temp_sensor(temp_sensor), .banks_active(banks_active),
		.dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.dqs_oe(dqs_oe), .busy(busy), .init_busy(init_busy));
	ctrl_model u_ctrl_model (.clk(clk), .link_ck(link_ck), .cs_n(cs_n),
		.ca(ca), .dq_out(dq_out), .dq_oe(dq_oe));
	task chk(input [63:0] got, input [63:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task tally_and_finish;
	begin
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task rd(input [7:0] a);
	begin
		u_ctrl_model.cmd(1'b1, a, 8'h00);
		b = u_ctrl_model.beats;
		chk(u_ctrl_model.nb, 4);
	end
	endtask
	task wait_init;
	integer k;
	begin
		for (k = 0; k < 1000 && init_busy !== 1'b0; k = k + 1) begin
			@(posedge clk);
			#1;
		end
		chk(init_busy, 1'b0);
	end
	endtask
	initial begin
		#100_000;
		miscompares = miscompares + 1;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		wait_init;
		for (i = 0; i < 3; i = i + 1)
			u_ctrl_model.cmd(1'b0, 8'h01 + 8'h0f * i[7:0], 8'h5a ^ i[7:0]);
		chk(busy, 1'b0);
		for (i = 0; i < 3; i = i + 1) begin
			rd(8'h01 + 8'h0f * i[7:0]);
			chk(b[7:0], 8'h5a ^ i[7:0]);
		end
		rd(8'h04);
		chk(b[2:0], 3'h3);
		u_ctrl_model.cmd(1'b0, 8'h04, 8'hff);
		rd(8'h04);
		chk(b[2:0], 3'h3);
		@(posedge clk) #1 temp_sensor = 3'h5;
		repeat (110) @(posedge clk);
		rd(8'h04);
		chk(b[2:0], 3'h5);
		u_ctrl_model.cmd(1'b0, 8'h20, 8'h00);
		rd(8'h20);
		chk(b, 64'h0000_ffff_0000_ffff);
		rd(8'h28);
		chk(b, 64'hffff_ffff_0000_0000);
		u_ctrl_model.cmd(1'b0, 8'h30, 8'ha5);
		rd(8'h30);
		chk(b[7:0], 8'h00);
		@(posedge clk) #1 banks_active = 1'b1;
		rd(8'h10);
		chk(b[7:0], 8'h5b);
		@(posedge clk) #1 banks_active = 1'b0;
		u_ctrl_model.cmd(1'b0, 8'h3f, 8'h00);
		wait_init;
		rd(8'h10);
		chk(b[7:0], 8'h00);
		tally_and_finish;
	end
endmodule
